// ===== hw/cc_timer_defines.svh
// Register offsets, field positions, reset values of the two-channel timer
`ifndef CC_TIMER_DEFINES_SVH
`define CC_TIMER_DEFINES_SVH

// ==========================================================
// Register offsets
`define OFS_STATUS_CTRL  4'h0
`define OFS_COUNT_HIGH   4'h1
`define OFS_COUNT_LOW    4'h2
`define OFS_MOD_HIGH     4'h3
`define OFS_MOD_LOW      4'h4
`define OFS_CH0_CTRL     4'h5
`define OFS_CH0_HIGH     4'h6
`define OFS_CH0_LOW      4'h7
`define OFS_CH1_CTRL     4'h8
`define OFS_CH1_HIGH     4'h9
`define OFS_CH1_LOW      4'hA

// ==========================================================
// Timer status and control fields
`define SC_WRAP_FLAG     7
`define SC_WRAP_IE       6
`define SC_STOP          5
`define SC_RESET         4
`define SC_PS_HI         2
`define PS_EXTERNAL      3'h7
`define SC_RESET_VALUE   8'h20

// ==========================================================
// Channel control fields
`define CH_FLAG          7
`define CH_IE            6
`define CH_COMPARE       4
`define CH_SEL_HI        3
`define CH_SEL_LO        2
`define CH_TOV           1
`define CH_RESET_VALUE   8'h00
`define SEL_RISE_TOGGLE  2'h1
`define SEL_FALL_CLEAR   2'h2
`define SEL_BOTH_SET     2'h3

// ==========================================================
// Other reset values
`define MOD_RESET_VALUE  16'hFFFF
`define VAL_RESET_VALUE  16'h0000

`endif

// ===== hw/cc_timer_pkg.sv
// Types shared by the two-channel timer
package cc_timer_pkg;
  typedef logic [15:0] count_t;
  typedef logic [7:0]  byte_t;
  typedef enum logic [1:0] {
    SRC_CH0,
    SRC_CH1,
    SRC_WRAP,
    SRC_NONE
  } irq_src_e;
endpackage

// ===== hw/cc_timer.sv
// Two-channel capture/compare timer with prescaler and modulo counter
`timescale 1ns/100ps
`include "cc_timer_defines.svh"

// Function
// - A 16-bit up-counter runs free or modulo and times both channels.
// - The modulo limit comes from software-written high and low registers.
// - Reading the counter never disturbs counting.
// - Two channels, each independently capture or compare.
// - Counter clock is one of seven prescaled rates or external pin.
// - A three-bit prescale select field chooses the counter clock.
// - An active capture edge copies the counter into the channel value.
// - Capture edge is rising, falling or either, per channel.
// - A capture raises an interrupt request when enabled.
// - Counter reaching compare value sets, clears or toggles the pin.
// - A compare match raises an interrupt request when enabled.
// - Each channel may toggle its pin on counter overflow.
// - One bit halts the counter, another resets counter and prescaler.
// - Timer takes over shared port pins only while it uses them.
// - Compare values written take effect at once; passed values miss.
// - Overflow flag at period end; compare flag at the compare match.
// - Interrupt priority is channel 0, channel 1, then overflow.
module cc_timer (
  input  wire logic       I_CLK,
  input  wire logic       I_RESET_N,
  input  wire logic [3:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  output logic      [7:0] O_RDATA,
  input  wire logic [1:0] I_CH_PIN,
  output logic      [1:0] O_CH_PIN,
  output logic      [1:0] O_CH_OE,
  input  wire logic       I_EXT_CLK,
  output logic            O_EXT_CLK_SEL,
  output logic            O_IRQ_REQ,
  output logic      [1:0] O_IRQ_SRC
);

  // ==========================================================
  // Helpers
  function automatic logic rate_tick(input logic [5:0] div,
                                     input logic [2:0] ps);
    logic [5:0] mask;
    mask = 6'(({6'h00, 1'b1} << ps) - 7'h01);
    return (div & mask) == mask;
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic prev, input logic cur);
    logic rise;
    logic fall;
    rise = !prev && cur;
    fall = prev && !cur;
    return (sel[0] && rise) || (sel[1] && fall);
  endfunction

  // ==========================================================
  // State
  cc_timer_pkg::byte_t  sc_q, sc_d;
  cc_timer_pkg::count_t cnt_q, cnt_d;
  cc_timer_pkg::count_t mod_q, mod_d;
  logic [5:0]           div_q, div_d;
  logic                 ext_prev_q, ext_prev_d;
  cc_timer_pkg::byte_t  ch_q [2];
  cc_timer_pkg::byte_t  ch_d [2];
  cc_timer_pkg::count_t val_q [2];
  cc_timer_pkg::count_t val_d [2];
  logic [1:0]           pin_prev_q, pin_prev_d;
  logic [1:0]           pin_q, pin_d;
  logic [1:0]           oe_d;
  logic [7:0]           rdata_d;
  logic                 irq_d;
  logic [1:0]           src_d;
  logic                 tick;
  logic                 wrap_ev;
  logic                 rst_wr;
  logic [1:0]           cap_ev, cmp_ev;
  cc_timer_pkg::irq_src_e src;

  // ==========================================================
  // Next-state logic
  always_comb begin
    sc_d       = sc_q;
    cnt_d      = cnt_q;
    mod_d      = mod_q;
    div_d      = div_q;
    ext_prev_d = I_EXT_CLK;
    pin_prev_d = I_CH_PIN;
    pin_d      = pin_q;
    oe_d       = '0;
    ch_d       = ch_q;
    val_d      = val_q;
    cap_ev     = '0;
    cmp_ev     = '0;
    wrap_ev    = 1'b0;
    rdata_d    = 8'h00;
    rst_wr     = I_WR && I_ADDR == `OFS_STATUS_CTRL && I_WDATA[`SC_RESET];

    // Counter clock source
    if (sc_q[`SC_PS_HI:0] == `PS_EXTERNAL) begin
      tick = !ext_prev_q && I_EXT_CLK;
    end else begin
      tick = rate_tick(div_q, sc_q[`SC_PS_HI:0]);
    end

    // Counting; the reset bit wins over everything else
    if (rst_wr) begin
      cnt_d = '0;
      div_d = '0;
    end else begin
      div_d = div_q + 6'h01;
      if (!sc_q[`SC_STOP] && tick) begin
        if (cnt_q == mod_q) begin
          cnt_d   = '0;
          wrap_ev = 1'b1;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
    end

    // Channels
    for (int i = 0; i < 2; i++) begin
      if (ch_q[i][`CH_COMPARE]) begin
        // Match against the live value, so a late write can miss
        cmp_ev[i] = !rst_wr && !sc_q[`SC_STOP] && tick &&
                    cnt_d == val_q[i];
        if (wrap_ev && ch_q[i][`CH_TOV]) begin
          pin_d[i] = !pin_q[i];
        end
        if (cmp_ev[i]) begin
          unique case (ch_q[i][`CH_SEL_HI:`CH_SEL_LO])
            `SEL_RISE_TOGGLE: pin_d[i] = !pin_q[i];
            `SEL_FALL_CLEAR:  pin_d[i] = 1'b0;
            `SEL_BOTH_SET:    pin_d[i] = 1'b1;
            default:          pin_d[i] = pin_q[i];
          endcase
        end
        oe_d[i] = ch_q[i][`CH_SEL_HI:`CH_SEL_LO] != 2'h0;
      end else begin
        cap_ev[i] = edge_hit(ch_q[i][`CH_SEL_HI:`CH_SEL_LO],
                             pin_prev_q[i], I_CH_PIN[i]);
        if (cap_ev[i]) begin
          val_d[i] = cnt_q;
        end
      end
    end

    // Register writes; a hardware set beats a clear in the same cycle
    if (I_WR) begin
      unique case (I_ADDR)
        `OFS_STATUS_CTRL: begin
          sc_d = I_WDATA & 8'hE7;
          sc_d[`SC_WRAP_FLAG] = sc_q[`SC_WRAP_FLAG] &
                                I_WDATA[`SC_WRAP_FLAG];
        end
        `OFS_MOD_HIGH: mod_d[15:8] = I_WDATA;
        `OFS_MOD_LOW:  mod_d[7:0]  = I_WDATA;
        `OFS_CH0_CTRL: begin
          ch_d[0] = I_WDATA & 8'hDE;
          ch_d[0][`CH_FLAG] = ch_q[0][`CH_FLAG] & I_WDATA[`CH_FLAG];
        end
        `OFS_CH1_CTRL: begin
          ch_d[1] = I_WDATA & 8'hDE;
          ch_d[1][`CH_FLAG] = ch_q[1][`CH_FLAG] & I_WDATA[`CH_FLAG];
        end
        `OFS_CH0_HIGH: val_d[0][15:8] = I_WDATA;
        `OFS_CH0_LOW:  val_d[0][7:0]  = I_WDATA;
        `OFS_CH1_HIGH: val_d[1][15:8] = I_WDATA;
        `OFS_CH1_LOW:  val_d[1][7:0]  = I_WDATA;
        default: ;
      endcase
    end
    if (wrap_ev) begin
      sc_d[`SC_WRAP_FLAG] = 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      if (cap_ev[i] || cmp_ev[i]) begin
        ch_d[i][`CH_FLAG] = 1'b1;
      end
    end

    // Reads have no side effects on any state
    if (I_RD) begin
      unique case (I_ADDR)
        `OFS_STATUS_CTRL: rdata_d = sc_q;
        `OFS_COUNT_HIGH:  rdata_d = cnt_q[15:8];
        `OFS_COUNT_LOW:   rdata_d = cnt_q[7:0];
        `OFS_MOD_HIGH:    rdata_d = mod_q[15:8];
        `OFS_MOD_LOW:     rdata_d = mod_q[7:0];
        `OFS_CH0_CTRL:    rdata_d = ch_q[0];
        `OFS_CH0_HIGH:    rdata_d = val_q[0][15:8];
        `OFS_CH0_LOW:     rdata_d = val_q[0][7:0];
        `OFS_CH1_CTRL:    rdata_d = ch_q[1];
        `OFS_CH1_HIGH:    rdata_d = val_q[1][15:8];
        `OFS_CH1_LOW:     rdata_d = val_q[1][7:0];
        default:          rdata_d = 8'h00;
      endcase
    end

    // Priority among pending enabled sources
    if (ch_d[0][`CH_FLAG] && ch_d[0][`CH_IE]) begin
      src = cc_timer_pkg::SRC_CH0;
    end else if (ch_d[1][`CH_FLAG] && ch_d[1][`CH_IE]) begin
      src = cc_timer_pkg::SRC_CH1;
    end else if (sc_d[`SC_WRAP_FLAG] && sc_d[`SC_WRAP_IE]) begin
      src = cc_timer_pkg::SRC_WRAP;
    end else begin
      src = cc_timer_pkg::SRC_NONE;
    end
    irq_d = src != cc_timer_pkg::SRC_NONE;
    src_d = src;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      sc_q          <= `SC_RESET_VALUE;
      cnt_q         <= '0;
      mod_q         <= `MOD_RESET_VALUE;
      div_q         <= '0;
      ext_prev_q    <= 1'b0;
      ch_q[0]       <= `CH_RESET_VALUE;
      ch_q[1]       <= `CH_RESET_VALUE;
      val_q[0]      <= `VAL_RESET_VALUE;
      val_q[1]      <= `VAL_RESET_VALUE;
      pin_prev_q    <= '0;
      pin_q         <= '0;
      O_CH_OE       <= '0;
      O_RDATA       <= 8'h00;
      O_EXT_CLK_SEL <= 1'b0;
      O_IRQ_REQ     <= 1'b0;
      O_IRQ_SRC     <= 2'h3;
    end else begin
      sc_q          <= sc_d;
      cnt_q         <= cnt_d;
      mod_q         <= mod_d;
      div_q         <= div_d;
      ext_prev_q    <= ext_prev_d;
      ch_q          <= ch_d;
      val_q         <= val_d;
      pin_prev_q    <= pin_prev_d;
      pin_q         <= pin_d;
      O_CH_OE       <= oe_d;
      O_RDATA       <= rdata_d;
      O_EXT_CLK_SEL <= sc_d[`SC_PS_HI:0] == `PS_EXTERNAL;
      O_IRQ_REQ     <= irq_d;
      O_IRQ_SRC     <= src_d;
    end
  end

  assign O_CH_PIN = pin_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);

  chk_count_wrap: assert property (
    !rst_wr && !sc_q[`SC_STOP] && tick && cnt_q == mod_q
    |=> cnt_q == 16'h0000 && sc_q[`SC_WRAP_FLAG])
    else $error("counter did not wrap at modulo");

  chk_count_step: assert property (
    !rst_wr && !sc_q[`SC_STOP] && tick && cnt_q != mod_q
    |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("counter did not step");

  chk_stop_hold: assert property (
    sc_q[`SC_STOP] && !rst_wr ##1 sc_q[`SC_STOP] && !rst_wr
    |=> $stable(cnt_q))
    else $error("halted counter moved");

  chk_reset_bit: assert property (
    rst_wr |=> cnt_q == 16'h0000 && div_q == 6'h00)
    else $error("reset bit did not clear counter");

  chk_read_quiet: assert property (
    I_RD && sc_q[`SC_STOP] && !I_WR |=> $stable(cnt_q))
    else $error("read disturbed the counter");

  chk_capture_load: assert property (
    !ch_q[0][`CH_COMPARE] && !pin_prev_q[0] && I_CH_PIN[0] &&
    ch_q[0][`CH_SEL_LO] && !(I_WR && I_ADDR inside {4'h6, 4'h7})
    |=> val_q[0] == $past(cnt_q) && ch_q[0][`CH_FLAG])
    else $error("capture did not latch counter");

  chk_compare_set: assert property (
    cmp_ev[1] && ch_q[1][`CH_SEL_HI:`CH_SEL_LO] == `SEL_BOTH_SET
    |=> O_CH_PIN[1] ##0 O_CH_OE[1])
    else $error("compare did not set pin");

  chk_tov_toggle: assert property (
    wrap_ev && ch_q[0][`CH_COMPARE] && ch_q[0][`CH_TOV] && !cmp_ev[0]
    |=> O_CH_PIN[0] != $past(O_CH_PIN[0]))
    else $error("overflow toggle missing");

  chk_irq_prio: assert property (
    ch_q[0][`CH_FLAG] && ch_q[0][`CH_IE] && ch_q[1][`CH_FLAG] &&
    ch_q[1][`CH_IE] ##1 ch_q[0][`CH_FLAG] && ch_q[0][`CH_IE]
    |-> O_IRQ_REQ && O_IRQ_SRC == 2'h0)
    else $error("channel 0 lost priority");

endmodule // cc_timer

// ===== verif/cc_pin_model.sv
// Pin-side partner: capture pin levels, external clock, pin resolution
`timescale 1ns/100ps
module cc_pin_model (
  input  wire logic       i_clk,
  input  wire logic [1:0] i_drive,
  input  wire logic [1:0] i_oe,
  output logic      [1:0] o_pin,
  output logic            o_ext_clk
);
  logic [1:0] level_q;

  // ==========================================================
  // Shared pins
  // Timer owns a pin only while enabled, else the outside level shows
  assign o_pin = (i_oe & i_drive) | (~i_oe & level_q);

  initial begin
    level_q = 2'h0;
    o_ext_clk = 1'b0;
  end

  task automatic set_pin(input int ch, input logic v);
    @(posedge i_clk);
    level_q[ch] <= v;
    repeat (3) @(posedge i_clk);
  endtask

  // Clock stands low between pulses; slow pulses stress edge detection
  task automatic ext_pulses(input int n, input int slow);
    repeat (n) begin
      @(posedge i_clk);
      o_ext_clk <= 1'b1;
      repeat (1 + slow) @(posedge i_clk);
      o_ext_clk <= 1'b0;
      repeat (1 + slow) @(posedge i_clk);
    end
    repeat (2) @(posedge i_clk);
  endtask
endmodule // cc_pin_model

// ===== verif/cc_timer_bench.sv
// Self-checking bench for the two-channel capture/compare timer
`timescale 1ns/100ps
module cc_timer_bench;
  logic        clk;
  logic        rst_n;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  rdata;
  logic [1:0]  pin_in;
  logic [1:0]  pin_out;
  logic [1:0]  pin_oe;
  logic        ext_clk;
  logic        ext_sel;
  logic        irq_req;
  logic [1:0]  irq_src;
  logic        rd_seen;
  logic [7:0]  got;
  logic [15:0] rv;
  logic [7:0]  exp_q[$];
  int          num_errors;
  int          n_compared;
  int          cycles;
  int          seed;
  int          k;
  int          cap;
  int          flag;

  cc_timer dut_u (.I_CLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr_en), .I_RD(rd_en), .O_RDATA(rdata),
    .I_CH_PIN(pin_in), .O_CH_PIN(pin_out), .O_CH_OE(pin_oe),
    .I_EXT_CLK(ext_clk), .O_EXT_CLK_SEL(ext_sel), .O_IRQ_REQ(irq_req),
    .O_IRQ_SRC(irq_src));
  cc_pin_model pin_u (.i_clk(clk), .i_drive(pin_out), .i_oe(pin_oe),
    .o_pin(pin_in), .o_ext_clk(ext_clk));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================
  // Checking
  task automatic cmp(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_rng(input logic [7:0] g, input int e);
    n_compared++;
    if ($isunknown(g) || g + 2 < e || g > e + 2) begin
      num_errors++;
      $display("wrong value count expected %0d seen %h", e, g);
    end
  endtask

  task automatic test_done;
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen && exp_q.size() > 0)
      cmp("read data", exp_q.pop_front(), rdata);
    rd_seen <= rd_en;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done;
    end
  end

  // ==========================================================
  // Register bus
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  task automatic rd_now(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic irq_is(input logic [7:0] e);
    @(negedge clk);
    cmp("irq", e, {5'h00, irq_req, irq_src});
  endtask

  task automatic pin_is(input logic [7:0] e);
    @(negedge clk);
    cmp("pins", e, {3'h0, ext_sel, pin_oe, pin_out});
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    seed = 11;
    num_errors = 0;
    n_compared = 0;
    cycles = 0;
    cap = 0;
    k = 0;
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    rd_seen = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    irq_is(8'h03);
    rd(4'h0, 8'h20);
    rd(4'h3, 8'hFF);
    rd(4'h5, 8'h00);
    rd(4'hA, 8'h00);
    wr(4'hB, 8'h5A);
    rd(4'hB, 8'h00);
    repeat (4) begin
      rv = 16'($random(seed));
      wr(4'h3, rv[15:8]);
      wr(4'h4, rv[7:0]);
      rd(4'h3, rv[15:8]);
      rd(4'h4, rv[7:0]);
    end
    wr(4'h3, 8'hFF);
    wr(4'h4, 8'hFF);
    for (int n = 0; n < 7; n++) begin
      wr(4'h0, {5'h02, n[2:0]});
      repeat (128) @(posedge clk);
      wr(4'h0, {5'h04, n[2:0]});
      rd_now(4'h2, got);
      cmp_rng(got, 128 >> n);
    end
    // Modulo 3 on the external clock: set at 2, toggle at the wrap
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h03);
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h02);
    wr(4'h5, 8'h1E);
    wr(4'h0, 8'h37);
    wr(4'h0, 8'h07);
    pin_u.ext_pulses(2, 0);
    rd(4'h2, 8'h02);
    rd(4'h2, 8'h02);
    rd(4'h1, 8'h00);
    pin_is(8'h15);
    pin_u.ext_pulses(2, 1);
    rd(4'h2, 8'h00);
    rd(4'h0, 8'h87);
    rd(4'h5, 8'h9E);
    pin_is(8'h14);
    wr(4'h0, 8'hC7);
    irq_is(8'h06);
    wr(4'h5, 8'hDE);
    irq_is(8'h04);
    wr(4'h5, 8'h5E);
    irq_is(8'h06);
    wr(4'h0, 8'h47);
    irq_is(8'h03);
    wr(4'h5, 8'h00);
    wr(4'h3, 8'hFF);
    wr(4'h4, 8'hFF);
    for (int s = 1; s < 4; s++) begin
      wr(4'h8, {4'h4, 2'(s), 2'h0});
      flag = 0;
      for (int e = 0; e < 2; e++) begin
        pin_u.ext_pulses(1, e);
        k++;
        pin_u.set_pin(1, e == 0);
        if (s[e]) begin
          cap = k;
          flag = 1;
        end
        rd(4'h9, 8'(cap >> 8));
        rd(4'hA, 8'(cap));
        irq_is(flag == 1 ? 8'h05 : 8'h03);
      end
    end
    // Selects 3, 2, 1 give set, clear, toggle
    for (int i = 0; i < 3; i++) begin
      wr(4'h9, 8'h00);
      wr(4'hA, 8'(k + 2));
      wr(4'h8, {4'h1, 2'(3 - i), 2'h0});
      pin_u.ext_pulses(2, i);
      k += 2;
      pin_is({4'h1, 2'h2, i != 1, 1'b0});
    end
    // A value already passed gives no match in this period
    wr(4'hA, 8'(k));
    wr(4'h8, 8'h14);
    pin_u.ext_pulses(2, 0);
    pin_is(8'h1A);
    rd(4'h8, 8'h14);
    // Modulo 16: raise the value after the wrap, lower it after the match
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h10);
    pin_u.ext_pulses(3, 0);
    irq_is(8'h06);
    wr(4'hA, 8'h0E);
    wr(4'h0, 8'h47);
    wr(4'h8, 8'h54);
    wr(4'h5, 8'h44);
    pin_u.ext_pulses(14, 0);
    irq_is(8'h05);
    // Both channel flags pending: channel 0 must win
    pin_u.set_pin(0, 1'b1);
    irq_is(8'h04);
    rd(4'h7, 8'h0E);
    wr(4'hA, 8'h04);
    wr(4'h8, 8'h54);
    pin_u.ext_pulses(7, 0);
    rd(4'h8, 8'hD4);
    rd(4'h0, 8'hC7);
    repeat (3) @(posedge clk);
    test_done;
  end
endmodule // cc_timer_bench
